// ### include/timer_event_flag_cfg.svh
// Offsets, bit positions and reset values of the timer event flag block.
// Assumes a byte address bus eight bits wide with one aligned word per register.
`ifndef TIMER_EVENT_FLAG_CFG_SVH
`define TIMER_EVENT_FLAG_CFG_SVH

// Register offsets
`define OFS_CONTROL 8'h00
`define OFS_ENABLE 8'h0c
`define OFS_FLAGS 8'h10
`define OFS_SWEVENT 8'h14
`define OFS_CAPTURE0 8'h34
`define OFS_CAPTURE1 8'h38

// Flag register bit positions; all but the overcapture bits are shared with the enable and software event registers
`define BIT_UPDATE 0
`define BIT_CHAN0 1
`define BIT_CHAN1 2
`define BIT_TRIGGER 6
`define BIT_OVCAP0 9
`define BIT_OVCAP1 10

// Control register bit positions
`define CTL_UPD_DIS 1
`define CTL_UPD_SRC 2
`define CTL_PAUSE 3
`define CTL_CH0_IN 4
`define CTL_CH1_IN 5
`define CTL_TRG_FALL 6

// Writable masks and reset values
`define ENABLE_MASK 32'h0000_0047
`define FLAGS_MASK 32'h0000_0647
`define CONTROL_MASK 32'h0000_007e
`define REG_RESET 32'h0000_0000

// Capture value width
`define CV_W 16

`endif

// ### include/timer_event_flag_pkg.sv
// Types of the timer event flag block.
// Assumes timer_event_flag_cfg.svh is on the include path.
`include "timer_event_flag_cfg.svh"

package timer_event_flag_pkg;

    // Events from the counter and channel datapaths, same clock
    typedef struct packed {
        logic overflow;
        logic restart;
        logic [1:0] capture;
        logic [1:0] compare;
    } timer_events_type;

    // Whole state of the block
    typedef struct packed {
        logic [31:0] enable;
        logic [31:0] flags;
        logic [31:0] control;
        logic [1:0][`CV_W-1:0] capture_value;
        logic [2:0] trig_sync;
        logic trig_level;
        logic [31:0] rdata;
        logic update_pulse;
        logic clear_pulse;
        logic trigger_pulse;
    } state_type;

endpackage

// ### core/timer_event_flag_logic.sv
// Interrupt enable, event flags and software event generation of a
// two-channel timer. Assumes counter, prescaler and channel datapaths
// sit outside and deliver one-cycle event pulses on ref_clk_i.
//
// Contract
// (RL1) Enable bits: trigger 6, ch1 2, ch0 1, update 0
// (RL2) Ch0 capture while flag set sets overcapture
// (RL3) Ch1 overcapture works like channel 0
// (RL4) Trigger event sets sticky trigger flag
// (RL5) Pause mode: both edges; else active edge
// (RL6) Ch0 flag: capture in input, compare output
// (RL7) Reading ch0 capture value clears flag (input)
// (RL8) Ch1 event flag works like channel 0
// (RL9) Update event sets sticky update flag
// (RL10) Flags clear on written zero; written one keeps them
// (RL11) Soft trigger sets trigger flag, self-clears
// (RL12) Soft ch0 event sets flag, captures counter (code captures in input mode only)
// (RL13) Soft ch1 event works like channel 0
// (RL14) Soft update clears counter and prescaler
// (RL15) Update disable: no event, still reinitialise
// (RL16) Source select one: only overflow flags update
// (RL17) Interrupt high while enabled flag set
`timescale 1ns/100ps
`default_nettype none
`include "timer_event_flag_cfg.svh"

module timer_event_flag_logic (
    // Clock, reset and enable
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Timer datapath
    input wire timer_event_flag_pkg::timer_events_type events_i,
    input wire logic [`CV_W-1:0] count_value_i,
    input wire logic trigger_pin_i,
    // Results
    output logic irq_o,
    output logic update_event_o,
    output logic counter_clear_o,
    output logic trigger_event_o,
    output logic [1:0][`CV_W-1:0] capture_value_o
);

    timer_event_flag_pkg::state_type st;
    timer_event_flag_pkg::state_type st_next;

    // Address match, used by every register access
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Per-channel bit position of the event and overcapture flags and of the input mode control bit
    function automatic int chan_bit(input int k);
        chan_bit = (k == 0) ? `BIT_CHAN0 : `BIT_CHAN1;
    endfunction

    function automatic int ovcap_bit(input int k);
        ovcap_bit = (k == 0) ? `BIT_OVCAP0 : `BIT_OVCAP1;
    endfunction

    function automatic int input_bit(input int k);
        input_bit = (k == 0) ? `CTL_CH0_IN : `CTL_CH1_IN;
    endfunction

    logic [31:0] soft_word;
    logic edge_seen;
    logic edge_rising;
    logic hw_trigger;
    logic reinit;
    logic upd_flag;
    logic [1:0] chan_input;
    logic [1:0] chan_capture;
    logic [1:0] chan_set;
    logic [1:0][7:0] cv_ofs;

    assign cv_ofs[0] = `OFS_CAPTURE0;
    assign cv_ofs[1] = `OFS_CAPTURE1;

    // Next-state logic
    always_comb begin
        st_next = st;
        st_next.update_pulse = 1'b0;
        st_next.clear_pulse = 1'b0;
        st_next.trigger_pulse = 1'b0;
        st_next.rdata = `REG_RESET;

        // Software event word exists for one cycle only, so it reads as zero
        soft_word = (wr_i && hit(addr_i, `OFS_SWEVENT)) ? wdata_i : `REG_RESET; // [RL11]

        // Pin synchroniser; stage 0 feeds only stage 1
        st_next.trig_sync = {st.trig_sync[1:0], trigger_pin_i};
        edge_seen = (st.trig_sync[2] == st.trig_sync[1])
            && (st.trig_sync[1] != st.trig_level);
        if (edge_seen) begin
            st_next.trig_level = st.trig_sync[1];
        end
        edge_rising = edge_seen && st.trig_sync[1];

        // Pause mode reacts to either edge, others to the chosen edge
        if (st.control[`CTL_PAUSE]) begin
            hw_trigger = edge_seen; // [RL5]
        end else if (st.control[`CTL_TRG_FALL]) begin
            hw_trigger = edge_seen && !edge_rising; // [RL5]
        end else begin
            hw_trigger = edge_rising; // [RL5]
        end

        // Update path; reinitialisation happens even when disabled
        reinit = soft_word[`BIT_UPDATE] || events_i.restart;
        st_next.clear_pulse = reinit; // [RL14] [RL15]
        st_next.update_pulse = !st.control[`CTL_UPD_DIS]
            && (reinit || events_i.overflow); // [RL15]
        upd_flag = !st.control[`CTL_UPD_DIS]
            && (events_i.overflow
            || (!st.control[`CTL_UPD_SRC] && reinit)); // [RL16]

        // Written zeros clear flags first; hardware sets win afterwards
        if (wr_i && hit(addr_i, `OFS_FLAGS)) begin
            st_next.flags = st.flags & (wdata_i | ~`FLAGS_MASK); // [RL10]
        end

        // Channel event, capture and overcapture
        for (int k = 0; k < 2; k++) begin
            chan_input[k] = st.control[input_bit(k)];
            chan_capture[k] = chan_input[k]
                && (events_i.capture[k] || soft_word[chan_bit(k)]); // [RL12] [RL13]
            chan_set[k] = soft_word[chan_bit(k)]
                || (chan_input[k] ? events_i.capture[k]
                : events_i.compare[k]); // [RL6] [RL8]
            if (rd_i && hit(addr_i, cv_ofs[k]) && chan_input[k]) begin
                st_next.flags[chan_bit(k)] = 1'b0; // [RL7] [RL8]
            end
            if (chan_capture[k]) begin
                st_next.capture_value[k] = count_value_i; // [RL12] [RL13]
                if (st.flags[chan_bit(k)]) begin
                    st_next.flags[ovcap_bit(k)] = 1'b1; // [RL2] [RL3]
                end
            end
            if (chan_set[k]) begin
                st_next.flags[chan_bit(k)] = 1'b1; // [RL6] [RL8] [RL12] [RL13]
            end
        end

        // Trigger from the pin or from software
        if (hw_trigger || soft_word[`BIT_TRIGGER]) begin
            st_next.flags[`BIT_TRIGGER] = 1'b1; // [RL4] [RL11]
            st_next.trigger_pulse = 1'b1;
        end

        if (upd_flag) begin
            st_next.flags[`BIT_UPDATE] = 1'b1; // [RL9]
        end

        // Configuration writes
        if (wr_i && hit(addr_i, `OFS_ENABLE)) begin
            st_next.enable = wdata_i & `ENABLE_MASK; // [RL1]
        end
        if (wr_i && hit(addr_i, `OFS_CONTROL)) begin
            st_next.control = wdata_i & `CONTROL_MASK;
        end

        // Read data, valid in the cycle after the strobe
        if (rd_i) begin
            if (hit(addr_i, `OFS_ENABLE)) begin
                st_next.rdata = st.enable;
            end else if (hit(addr_i, `OFS_FLAGS)) begin
                st_next.rdata = st.flags;
            end else if (hit(addr_i, `OFS_CONTROL)) begin
                st_next.rdata = st.control;
            end else if (hit(addr_i, `OFS_CAPTURE0)) begin
                st_next.rdata = {{(32-`CV_W){1'b0}}, st.capture_value[0]};
            end else if (hit(addr_i, `OFS_CAPTURE1)) begin
                st_next.rdata = {{(32-`CV_W){1'b0}}, st.capture_value[1]};
            end else begin
                st_next.rdata = `REG_RESET;
            end
        end
    end

    // State register; clock enable low freezes everything
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else if (clk_en_i) begin
            st <= st_next;
        end
    end

    // Overcapture flags share their channel's enable
    assign irq_o = |(st.flags[6:0] & st.enable[6:0])
        || (st.flags[`BIT_OVCAP0] && st.enable[`BIT_CHAN0])
        || (st.flags[`BIT_OVCAP1] && st.enable[`BIT_CHAN1]); // [RL17] [RL1]

    // Registered outputs
    assign rdata_o = st.rdata;
    assign update_event_o = st.update_pulse;
    assign counter_clear_o = st.clear_pulse;
    assign trigger_event_o = st.trigger_pulse;
    assign capture_value_o = st.capture_value;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    // Overflow with updates allowed leaves the update flag set
    a_update_flag_set: assert property ( // [RL9]
        clk_en_i && events_i.overflow && !st.control[`CTL_UPD_DIS]
        |=> st.flags[`BIT_UPDATE] && update_event_o)
        else $error("update flag not set by overflow");

    // Soft trigger sets the flag and pulses the trigger output once
    a_soft_trigger_flag: assert property ( // [RL11]
        clk_en_i && wr_i && hit(addr_i, `OFS_SWEVENT) && wdata_i[`BIT_TRIGGER]
        |=> st.flags[`BIT_TRIGGER] && trigger_event_o
        ##1 !$past(clk_en_i) || !trigger_event_o
        || $past(hw_trigger || soft_word[`BIT_TRIGGER]))
        else $error("soft trigger not seen");

    // Soft update reinitialises even while updates are disabled
    a_soft_update_clear: assert property ( // [RL14]
        clk_en_i && wr_i && hit(addr_i, `OFS_SWEVENT) && wdata_i[`BIT_UPDATE]
        |=> counter_clear_o)
        else $error("soft update did not clear counter");

    // No update event while updates are disabled
    a_disable_no_update: assert property ( // [RL15]
        clk_en_i && st.control[`CTL_UPD_DIS] |=> !update_event_o)
        else $error("update event while disabled");

    // With source select one, a restart alone leaves the flag clear
    a_update_source_only: assert property ( // [RL16]
        clk_en_i && st.control[`CTL_UPD_SRC] && !events_i.overflow
        && !st.flags[`BIT_UPDATE]
        |=> !st.flags[`BIT_UPDATE])
        else $error("update flag from non-overflow source");

    // Writing one keeps a set flag
    a_flag_write_one: assert property ( // [RL10]
        clk_en_i && wr_i && hit(addr_i, `OFS_FLAGS) && wdata_i[`BIT_TRIGGER]
        && st.flags[`BIT_TRIGGER]
        |=> st.flags[`BIT_TRIGGER])
        else $error("flag lost on written one");

    // Capture in input mode sets the flag and stores the counter
    a_chan0_capture: assert property ( // [RL6]
        clk_en_i && st.control[`CTL_CH0_IN] && events_i.capture[0]
        |=> st.flags[`BIT_CHAN0] && st.capture_value[0] == $past(count_value_i))
        else $error("channel 0 capture wrong");

    // Second capture before clearing marks overcapture
    a_chan0_overcapture: assert property ( // [RL2]
        clk_en_i && st.control[`CTL_CH0_IN] && events_i.capture[0]
        && st.flags[`BIT_CHAN0]
        |=> st.flags[`BIT_OVCAP0])
        else $error("channel 0 overcapture missed");

    a_chan1_overcapture: assert property ( // [RL3]
        clk_en_i && st.control[`CTL_CH1_IN] && events_i.capture[1]
        && st.flags[`BIT_CHAN1]
        |=> st.flags[`BIT_OVCAP1])
        else $error("channel 1 overcapture missed");

    // Capture value read clears the flag when nothing sets it again
    a_capture_read_clear: assert property ( // [RL7]
        clk_en_i && rd_i && hit(addr_i, `OFS_CAPTURE0) && st.control[`CTL_CH0_IN]
        && !events_i.capture[0]
        |=> !st.flags[`BIT_CHAN0])
        else $error("capture read did not clear flag");

    // Enabling a pending update flag raises the interrupt
    a_irq_enable_level: assert property ( // [RL17]
        clk_en_i && wr_i && hit(addr_i, `OFS_ENABLE) && wdata_i[`BIT_UPDATE]
        && st.flags[`BIT_UPDATE]
        |=> irq_o)
        else $error("interrupt not raised");

    // Software event register reads back zero
    a_swevent_reads_zero: assert property ( // [RL11]
        clk_en_i && rd_i && hit(addr_i, `OFS_SWEVENT) |=> rdata_o == 32'h0000_0000)
        else $error("software event register not zero");

    // Channel 1 capture stores the counter and sets its flag
    a_chan1_capture: assert property ( // [RL8]
        clk_en_i && st.control[`CTL_CH1_IN] && events_i.capture[1]
        |=> st.flags[`BIT_CHAN1] && st.capture_value[1] == $past(count_value_i))
        else $error("channel 1 capture wrong");

    // Compare in output mode sets the channel 0 flag
    a_chan0_compare: assert property ( // [RL6]
        clk_en_i && !st.control[`CTL_CH0_IN] && events_i.compare[0]
        |=> st.flags[`BIT_CHAN0])
        else $error("channel 0 compare flag missed");

    // Capture value read clears the channel 1 flag as well
    a_chan1_read_clear: assert property ( // [RL8]
        clk_en_i && rd_i && hit(addr_i, `OFS_CAPTURE1) && st.control[`CTL_CH1_IN]
        && !events_i.capture[1]
        |=> !st.flags[`BIT_CHAN1])
        else $error("channel 1 capture read did not clear flag");

    // Soft channel 0 event sets the flag; input mode also captures
    a_soft_chan0_event: assert property ( // [RL12]
        clk_en_i && wr_i && hit(addr_i, `OFS_SWEVENT) && wdata_i[`BIT_CHAN0]
        |=> st.flags[`BIT_CHAN0] && (!$past(st.control[`CTL_CH0_IN])
        || st.capture_value[0] == $past(count_value_i)))
        else $error("soft channel 0 event wrong");

    // Pause mode turns either settled pin edge into a trigger
    a_pause_edge_trigger: assert property ( // [RL5]
        clk_en_i && st.control[`CTL_PAUSE] && edge_seen
        |=> st.flags[`BIT_TRIGGER] && trigger_event_o)
        else $error("pause mode edge missed");

    // Outside pause mode the inactive edge stays quiet
    a_inactive_edge_quiet: assert property ( // [RL5]
        clk_en_i && edge_seen && !st.control[`CTL_PAUSE]
        && (st.trig_sync[1] == st.control[`CTL_TRG_FALL])
        && !(wr_i && hit(addr_i, `OFS_SWEVENT) && wdata_i[`BIT_TRIGGER])
        |=> !trigger_event_o)
        else $error("trigger on inactive edge");

    // Written zero clears the update flag when nothing sets it
    a_flag_write_zero: assert property ( // [RL10]
        clk_en_i && wr_i && hit(addr_i, `OFS_FLAGS) && !wdata_i[`BIT_UPDATE]
        && !events_i.overflow && !events_i.restart
        |=> !st.flags[`BIT_UPDATE])
        else $error("update flag not cleared by written zero");

    // Restart or soft update while disabled still clears the counter
    a_disabled_reinit: assert property ( // [RL15]
        clk_en_i && st.control[`CTL_UPD_DIS] && (events_i.restart
        || (wr_i && hit(addr_i, `OFS_SWEVENT) && wdata_i[`BIT_UPDATE]))
        |=> counter_clear_o && !update_event_o)
        else $error("reinit while disabled wrong");

    // No flag set means no interrupt, whatever is enabled
    a_irq_no_flags: assert property ( // [RL17]
        st.flags == 32'h0000_0000 |-> !irq_o)
        else $error("interrupt without a flag");

endmodule

`default_nettype wire

// ### verif/tb_timer_event_flag_logic.sv
// Self-checking bench for the timer event flag block.
// Assumes the design files and timer_event_flag_cfg.svh are on the include path.
`include "timer_event_flag_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_timer_event_flag_logic;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    timer_event_flag_pkg::timer_events_type events_i = 6'h00;
    logic [`CV_W-1:0] count_value_i = 16'h0000;
    logic trigger_pin_i = 1'b0;
    logic irq_o;
    logic update_event_o;
    logic counter_clear_o;
    logic trigger_event_o;
    logic [1:0][`CV_W-1:0] capture_value_o;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    int n_upd = 0;
    int n_clr = 0;
    int n_trg = 0;

    // Device under test; clock enable is driven for the freeze test
    timer_event_flag_logic dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .events_i(events_i), .count_value_i(count_value_i), .trigger_pin_i(trigger_pin_i),
        .irq_o(irq_o), .update_event_o(update_event_o), .counter_clear_o(counter_clear_o),
        .trigger_event_o(trigger_event_o), .capture_value_o(capture_value_o));

    // 50 ns clock period
    always #25 ref_clk_i = ~ref_clk_i;

    // Pulse counters sample mid-cycle, away from the launching edge
    always @(negedge ref_clk_i) begin
        cycles++;
        n_upd += (update_event_o === 1'b1);
        n_clr += (counter_clear_o === 1'b1);
        n_trg += (trigger_event_o === 1'b1);
        if (cycles == 5000) begin
            n_errors++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask

    task automatic ev(input logic [5:0] e);
        @(posedge ref_clk_i);
        events_i <= e;
        @(posedge ref_clk_i);
        events_i <= 6'h00;
    endtask

    // Level outputs are checked after the write has settled
    task automatic irq_is(input logic exp);
        repeat (2) @(posedge ref_clk_i);
        #1 chk({31'h0, irq_o}, {31'h0, exp});
    endtask

    task automatic pin(input logic v);
        trigger_pin_i <= v;
        repeat (8) @(posedge ref_clk_i);
    endtask

    task automatic results;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        // Reset values, reserved bits and an unmapped address
        rd(`OFS_ENABLE, 32'h0);
        rd(`OFS_FLAGS, 32'h0);
        wr(`OFS_ENABLE, 32'hffff_ffff);
        rd(`OFS_ENABLE, 32'h0000_0047);
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, 32'h0);
        $display("test registers done");
        // Capture, overcapture, read clear and soft events per channel
        for (int ch = 0; ch < 2; ch++) begin
            wr(`OFS_CONTROL, 32'h0000_0030);
            count_value_i <= 16'h1234 + 16'(ch);
            ev(6'h04 << ch);
            rd(`OFS_FLAGS, 32'h2 << ch);
            chk(32'(capture_value_o[ch]), 32'h1234 + ch);
            irq_is(1'b1);
            ev(6'h04 << ch);
            rd(`OFS_FLAGS, (32'h2 << ch) | (32'h200 << ch));
            rd(`OFS_CAPTURE0 + 8'(4 * ch), 32'h1234 + ch);
            rd(`OFS_FLAGS, 32'h200 << ch);
            wr(`OFS_FLAGS, 32'hffff_ffff);
            rd(`OFS_FLAGS, 32'h200 << ch);
            wr(`OFS_FLAGS, 32'h0);
            rd(`OFS_FLAGS, 32'h0);
            irq_is(1'b0);
            count_value_i <= 16'h0abc + 16'(ch);
            wr(`OFS_SWEVENT, 32'h2 << ch);
            rd(`OFS_SWEVENT, 32'h0);
            rd(`OFS_FLAGS, 32'h2 << ch);
            rd(`OFS_CAPTURE0 + 8'(4 * ch), 32'h0abc + ch);
            // Output mode: compare sets the flag, capture read keeps it
            wr(`OFS_CONTROL, 32'h0);
            ev(6'h01 << ch);
            rd(`OFS_CAPTURE0 + 8'(4 * ch), 32'h0abc + ch);
            rd(`OFS_FLAGS, 32'h2 << ch);
            wr(`OFS_FLAGS, 32'h0);
        end
        $display("test channels done");
        // Clock enable low: an overflow is lost
        clk_en_i <= 1'b0;
        ev(6'h20);
        clk_en_i <= 1'b1;
        rd(`OFS_FLAGS, 32'h0);
        // Update sources, disable and source select
        ev(6'h20);
        rd(`OFS_FLAGS, 32'h1);
        wr(`OFS_ENABLE, 32'h0);
        irq_is(1'b0);
        wr(`OFS_ENABLE, 32'h1);
        irq_is(1'b1);
        wr(`OFS_FLAGS, 32'h0);
        wr(`OFS_SWEVENT, 32'h1);
        rd(`OFS_FLAGS, 32'h1);
        chk(n_clr, 1);
        chk(n_upd, 2);
        wr(`OFS_FLAGS, 32'h0);
        wr(`OFS_CONTROL, 32'h2);
        wr(`OFS_SWEVENT, 32'h1);
        rd(`OFS_FLAGS, 32'h0);
        chk(n_clr, 2);
        chk(n_upd, 2);
        wr(`OFS_CONTROL, 32'h4);
        wr(`OFS_SWEVENT, 32'h1);
        ev(6'h10);
        rd(`OFS_FLAGS, 32'h0);
        ev(6'h20);
        rd(`OFS_FLAGS, 32'h1);
        chk(n_upd, 5);
        chk(n_clr, 4);
        wr(`OFS_FLAGS, 32'h0);
        $display("test update done");
        // Soft trigger, then pin edges in normal and pause mode
        wr(`OFS_ENABLE, 32'h40);
        wr(`OFS_CONTROL, 32'h0);
        wr(`OFS_SWEVENT, 32'h40);
        rd(`OFS_FLAGS, 32'h40);
        irq_is(1'b1);
        wr(`OFS_FLAGS, 32'h0);
        repeat (3) @(posedge ref_clk_i);
        pin(1'b1);
        rd(`OFS_FLAGS, 32'h40);
        wr(`OFS_FLAGS, 32'h0);
        pin(1'b0);
        rd(`OFS_FLAGS, 32'h0);
        wr(`OFS_CONTROL, 32'h8);
        pin(1'b1);
        rd(`OFS_FLAGS, 32'h40);
        wr(`OFS_FLAGS, 32'h0);
        pin(1'b0);
        rd(`OFS_FLAGS, 32'h40);
        // Falling active edge outside pause mode
        wr(`OFS_FLAGS, 32'h0);
        wr(`OFS_CONTROL, 32'h40);
        pin(1'b1);
        rd(`OFS_FLAGS, 32'h0);
        pin(1'b0);
        rd(`OFS_FLAGS, 32'h40);
        chk(n_trg, 5);
        $display("test trigger done");
        // Reset in mid-run clears registers and the interrupt
        @(posedge ref_clk_i);
        nrst_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        rd(`OFS_FLAGS, 32'h0);
        rd(`OFS_ENABLE, 32'h0);
        irq_is(1'b0);
        $display("test reset done");
        results();
    end
endmodule
`default_nettype wire
